// [design/root_hub_defines.vh]
/*
  Constants for the root hub status register block: register byte offsets,
  bit positions of the global status word and of the port status words,
  and the fixed port count.
  Assumes the includer is plain Verilog-2005 and uses the names as given.
*/
`ifndef ROOT_HUB_DEFINES_VH
`define ROOT_HUB_DEFINES_VH

// register byte offsets
`define OFS_HUB_GLOBAL_STATUS 8'h50
`define OFS_HUB_PORT_STATUS0 8'h54
`define PORT_STRIDE 8'h04

// hardware port count, configured count may be lower
`define MAX_PORTS 4

// global status word
`define G_CLEAR_WAKE_BIT 31
`define G_OC_CHANGE_BIT 17
`define G_SET_GLOBAL_BIT 16
`define G_WAKE_ENABLE_BIT 15
`define G_OC_FLAG_BIT 1
`define G_CLR_GLOBAL_BIT 0

// port status word, status half
`define P_CONNECT_BIT 0
`define P_ENABLE_BIT 1
`define P_SUSPEND_BIT 2
`define P_OC_BIT 3
`define P_RESET_BIT 4
`define P_POWER_BIT 8
`define P_LOW_SPEED_BIT 9

// port status word, change half
`define P_CONNECT_CHG_BIT 16
`define P_ENABLE_CHG_BIT 17
`define P_SUSPEND_CHG_BIT 18
`define P_OC_CHG_BIT 19
`define P_RESET_CHG_BIT 20

`define RESET_WORD 32'h00000000

`endif

// [design/root_hub_global_status_regs.v]
/*
  Root hub global status word and per-port status words of a full/low-speed
  host controller function, reached over a simple register strobe port.
  Assumes: all inputs synchronous to clock, the register port gives one
  access per strobe, the surrounding controller supplies the hub
  configuration, the transaction-busy level and the suspend state.
*/
// Operation
// - writing 1 to bit 31 clears remote wake-up enable; 0 does nothing
// - hardware change of global overcurrent flag sets change flag bit 17
// - driver clears bit 17 by writing 1; writing 0 leaves it
// - bit 16 always reads 0, no local power change
// - writing 1 to bit 16 in global mode powers all ports on
// - per-port mode: set-global-power affects only ports with mask bit clear
// - with wake-up enabled, connect change while suspended requests resume
// - writing 1 to bit 15 sets wake-up enable, read back there
// - global reporting: bit 1 shows overcurrent condition present
// - per-port overcurrent protection: global overcurrent bit reads 0
// - bit 0 always reads 0, no local power status
// - writing 1 to bit 0 in global mode powers all ports off
// - per-port mode: clear-global-power affects only ports with mask clear
// - one port status register per configured downstream port
// - port word: status in low half, change flags in high half
// - enable and power commands wait until the running transaction completes
// - power control mask bits mark ports following per-port commands only
`include "root_hub_defines.vh"
`default_nettype none

module root_hub_global_status_regs (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_ack,
  // hub configuration
  input wire [2:0] downstream_port_count,
  input wire power_switch_mode,
  input wire per_port_overcurrent_mode,
  input wire [15:0] per_port_power_mask,
  // controller state
  input wire transaction_busy,
  input wire suspended_state,
  // port side
  input wire global_overcurrent_in,
  input wire [3:0] connect_in,
  input wire [3:0] low_speed_in,
  input wire [3:0] port_overcurrent_in,
  output reg [3:0] port_power,
  output reg remote_wakeup_enable_flag,
  output reg resume_request
);

  reg global_overcurrent_flag;
  reg global_overcurrent_change;
  wire glob_hit;
  wire glob_wr;
  wire oc_now;
  wire oc_event;
  wire set_global;
  wire clr_global;
  wire wake_clear_cmd;
  wire wake_set_cmd;
  wire oc_change_clear_cmd;
  wire [127:0] port_word;
  wire [3:0] port_hit;
  wire [3:0] connect_event;
  wire [3:0] next_power;
  reg [31:0] next_rdata;
  integer k;

  assign glob_hit = (reg_addr == `OFS_HUB_GLOBAL_STATUS);
  assign glob_wr = reg_wr & glob_hit;
  assign set_global = glob_wr & reg_wdata[`G_SET_GLOBAL_BIT];
  assign clr_global = glob_wr & reg_wdata[`G_CLR_GLOBAL_BIT];
  // per-port protection forces the global indicator low
  assign oc_now = global_overcurrent_in & ~per_port_overcurrent_mode;
  assign oc_event = oc_now ^ global_overcurrent_flag;
  assign wake_clear_cmd = glob_wr & reg_wdata[`G_CLEAR_WAKE_BIT];
  assign wake_set_cmd = glob_wr & reg_wdata[`G_WAKE_ENABLE_BIT];
  assign oc_change_clear_cmd = glob_wr & reg_wdata[`G_OC_CHANGE_BIT];

  // global overcurrent indicator and its change flag
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      global_overcurrent_flag <= 1'b0;
      global_overcurrent_change <= 1'b0;
    end
    else
    begin
      global_overcurrent_flag <= oc_now;
      // set wins over a same-cycle clear so no change is lost
      if (oc_event)
        global_overcurrent_change <= 1'b1;
      else if (oc_change_clear_cmd)
        global_overcurrent_change <= 1'b0;
    end
  end

  // a write with both bits set leaves the flag cleared
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      remote_wakeup_enable_flag <= 1'b0;
    else if (wake_clear_cmd)
      remote_wakeup_enable_flag <= 1'b0;
    else if (wake_set_cmd)
      remote_wakeup_enable_flag <= 1'b1;
  end

  // one-cycle pulse; the controller's own state machine does the resume
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      resume_request <= 1'b0;
    else
      resume_request <= remote_wakeup_enable_flag & suspended_state & (|connect_event);
  end

  // mirrors the per-port power flops so the pins come straight from a flop
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      port_power <= 4'h0;
    else
      port_power <= next_power;
  end

  genvar i;
  generate
    for (i = 0; i < `MAX_PORTS; i = i + 1)
    begin : port
      localparam integer PORT_OFFSET = `OFS_HUB_PORT_STATUS0 + `PORT_STRIDE * i;
      localparam [7:0] PORT_ADDR = PORT_OFFSET[7:0];
      reg connect_q;
      reg enabled;
      reg power;
      reg overcurrent;
      reg low_speed;
      reg connect_change_flag;
      reg port_enable_change;
      reg port_overcurrent_change;
      reg pend_set_en;
      reg pend_clr_en;
      reg pend_set_pw;
      reg pend_clr_pw;
      wire active;
      wire wr;
      wire globally_steered;
      wire want_set_en;
      wire want_clr_en;
      wire want_set_pw;
      wire want_clr_pw;
      wire apply;
      wire pw_after;
      wire en_after;
      wire oc_in;
      wire hw_drop;
      wire oc_edge;
      wire clr_connect_chg;
      wire clr_enable_chg;
      wire clr_oc_chg;
      reg [31:0] status_word;

      assign active = (i < downstream_port_count);
      assign port_hit[i] = active & (reg_addr == PORT_ADDR);
      assign wr = reg_wr & port_hit[i];
      // mask bit 0 is reserved, port n uses mask bit n
      assign globally_steered = ~power_switch_mode | ~per_port_power_mask[i + 1];
      assign want_set_en = pend_set_en | (wr & reg_wdata[`P_ENABLE_BIT]);
      assign want_clr_en = pend_clr_en | (wr & reg_wdata[`P_CONNECT_BIT]);
      assign want_set_pw = pend_set_pw | (wr & reg_wdata[`P_POWER_BIT]) | (set_global & globally_steered);
      assign want_clr_pw = pend_clr_pw | (wr & reg_wdata[`P_LOW_SPEED_BIT]) | (clr_global & globally_steered);
      // enable and power commands are held while a transaction runs
      assign apply = ~transaction_busy;
      assign pw_after = apply ? ((power | want_set_pw) & ~want_clr_pw) : power;
      assign oc_in = port_overcurrent_in[i] & per_port_overcurrent_mode;
      // hardware drops enable on disconnect, power loss or overcurrent
      assign hw_drop = enabled & (~connect_in[i] | ~pw_after | oc_in);
      assign en_after = apply ? ((enabled | (want_set_en & connect_in[i])) & ~want_clr_en & ~hw_drop)
                              : (enabled & ~hw_drop);
      assign connect_event[i] = active & (connect_in[i] ^ connect_q);
      assign oc_edge = active & (oc_in ^ overcurrent);
      assign clr_connect_chg = wr & reg_wdata[`P_CONNECT_CHG_BIT];
      assign clr_enable_chg = wr & reg_wdata[`P_ENABLE_CHG_BIT];
      assign clr_oc_chg = wr & reg_wdata[`P_OC_CHG_BIT];
      assign next_power[i] = active & pw_after;

      // port status, held at 0 while the port is beyond the configured count
      always @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          connect_q <= 1'b0;
          enabled <= 1'b0;
          power <= 1'b0;
          overcurrent <= 1'b0;
          low_speed <= 1'b0;
        end
        else
        begin
          connect_q <= connect_in[i] & active;
          low_speed <= low_speed_in[i] & connect_in[i] & active;
          overcurrent <= oc_in & active;
          power <= next_power[i];
          enabled <= en_after & active;
        end
      end

      // commands caught during a transaction wait here until it completes
      always @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          pend_set_en <= 1'b0;
          pend_clr_en <= 1'b0;
          pend_set_pw <= 1'b0;
          pend_clr_pw <= 1'b0;
        end
        else
        begin
          pend_set_en <= ~apply & want_set_en;
          pend_clr_en <= ~apply & want_clr_en;
          pend_set_pw <= ~apply & want_set_pw;
          pend_clr_pw <= ~apply & want_clr_pw;
        end
      end

      // change flags: hardware set beats a same-cycle write of 1
      always @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          connect_change_flag <= 1'b0;
          port_enable_change <= 1'b0;
          port_overcurrent_change <= 1'b0;
        end
        else
        begin
          if (connect_event[i])
            connect_change_flag <= 1'b1;
          else if (clr_connect_chg)
            connect_change_flag <= 1'b0;
          if (hw_drop)
            port_enable_change <= 1'b1;
          else if (clr_enable_chg)
            port_enable_change <= 1'b0;
          if (oc_edge)
            port_overcurrent_change <= 1'b1;
          else if (clr_oc_chg)
            port_overcurrent_change <= 1'b0;
        end
      end

      // suspend, reset and their change flags are not kept here and read 0
      always @*
      begin
        status_word = `RESET_WORD;
        status_word[`P_CONNECT_BIT] = connect_q;
        status_word[`P_ENABLE_BIT] = enabled;
        status_word[`P_OC_BIT] = overcurrent;
        status_word[`P_POWER_BIT] = power;
        status_word[`P_LOW_SPEED_BIT] = low_speed;
        status_word[`P_CONNECT_CHG_BIT] = connect_change_flag;
        status_word[`P_ENABLE_CHG_BIT] = port_enable_change;
        status_word[`P_OC_CHG_BIT] = port_overcurrent_change;
      end
      assign port_word[32 * i +: 32] = status_word;
    end
  endgenerate

  always @*
  begin
    next_rdata = `RESET_WORD;
    if (glob_hit)
    begin
      next_rdata[`G_OC_CHANGE_BIT] = global_overcurrent_change;
      next_rdata[`G_SET_GLOBAL_BIT] = 1'b0;
      next_rdata[`G_WAKE_ENABLE_BIT] = remote_wakeup_enable_flag;
      next_rdata[`G_OC_FLAG_BIT] = global_overcurrent_flag;
      next_rdata[`G_CLR_GLOBAL_BIT] = 1'b0;
    end
    // an inactive port never hits, so its address reads 0
    for (k = 0; k < `MAX_PORTS; k = k + 1)
    begin
      if (port_hit[k])
        next_rdata = port_word[32 * k +: 32];
    end
  end

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= `RESET_WORD;
      reg_ack <= 1'b0;
    end
    else
    begin
      reg_ack <= reg_rd | reg_wr;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

endmodule // root_hub_global_status_regs

`default_nettype wire

// [tb/root_hub_sva.sv]
/* checker for the root hub status registers
   assumes it is bound onto the top module */
`default_nettype none
module root_hub_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  // configuration and state
  input wire logic [2:0] downstream_port_count,
  input wire logic power_switch_mode,
  input wire logic per_port_overcurrent_mode,
  input wire logic [15:0] per_port_power_mask,
  input wire logic transaction_busy,
  input wire logic suspended_state,
  // port side
  input wire logic [3:0] port_power,
  input wire logic remote_wakeup_enable_flag,
  input wire logic resume_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire g_wr = reg_wr && reg_addr == 8'h50;
  wire g_rd = reg_rd && reg_addr == 8'h50;
  wire [3:0] act = ~(4'hF << downstream_port_count);
  property p_ack; reg_wr || reg_rd |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("access not acked");
  property p_wset; g_wr && reg_wdata[15] && !reg_wdata[31] |=> remote_wakeup_enable_flag; endproperty
  a_wset: assert property (p_wset) else $error("wake not set");
  property p_wclr; g_wr && reg_wdata[31] |=> !remote_wakeup_enable_flag; endproperty
  a_wclr: assert property (p_wclr) else $error("wake not cleared");
  property p_lpz; g_rd |=> !reg_rdata[16] && !reg_rdata[0]; endproperty
  a_lpz: assert property (p_lpz) else $error("power bits read 1");
  property p_ocz; g_rd && per_port_overcurrent_mode && $past(per_port_overcurrent_mode) |=> !reg_rdata[1]; endproperty
  a_ocz: assert property (p_ocz) else $error("overcurrent bit set");
  // a command pending from a busy spell could land on the same edge
  property p_on; g_wr && reg_wdata[16] && !reg_wdata[0] && !power_switch_mode && !transaction_busy
    && !$past(transaction_busy) |=> (port_power & act) == act; endproperty
  a_on: assert property (p_on) else $error("ports not powered");
  property p_off; g_wr && reg_wdata[0] && !power_switch_mode && !transaction_busy
    && !$past(transaction_busy) |=> (port_power & act) == 4'h0; endproperty
  a_off: assert property (p_off) else $error("ports still powered");
  property p_mask; g_wr && (reg_wdata[16] || reg_wdata[0]) && power_switch_mode && !transaction_busy
    && !$past(transaction_busy) |=> $stable(port_power & per_port_power_mask[4:1]); endproperty
  a_mask: assert property (p_mask) else $error("masked port moved");
  property p_busy; transaction_busy |=> $stable(port_power); endproperty
  a_busy: assert property (p_busy) else $error("power moved while busy");
  property p_res; resume_request |-> $past(remote_wakeup_enable_flag) && $past(suspended_state); endproperty
  a_res: assert property (p_res) else $error("resume without cause");
  c_res: cover property (resume_request);
  c_pend: cover property (transaction_busy && reg_wr);
  c_mask: cover property (g_wr && power_switch_mode);
endmodule // root_hub_sva
bind root_hub_global_status_regs root_hub_sva u_root_hub_sva (
  .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .downstream_port_count(downstream_port_count), .power_switch_mode(power_switch_mode),
  .per_port_overcurrent_mode(per_port_overcurrent_mode), .per_port_power_mask(per_port_power_mask),
  .transaction_busy(transaction_busy), .suspended_state(suspended_state), .port_power(port_power),
  .remote_wakeup_enable_flag(remote_wakeup_enable_flag), .resume_request(resume_request)
);
`default_nettype wire

// [tb/root_hub_port_model.sv]
/* downstream ports with their devices
   assumes the bench picks which ports hold a device */
`default_nettype none
module root_hub_port_model (
  // device choice
  input wire logic [3:0] attach,
  input wire logic [3:0] slow,
  // hub side
  input wire logic [3:0] port_power,
  output logic [3:0] connect_in,
  output logic [3:0] low_speed_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a device only shows up once its port has power
  assign connect_in = attach & port_power;
  // speed line pulled low with nothing connected
  assign low_speed_in = slow & connect_in;
endmodule // root_hub_port_model
`default_nettype wire

// [tb/tb_top.sv]
/* self-checking bench for the root hub status registers
   assumes the checker binds itself to the design */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_b, reg_wr, reg_rd, power_switch_mode, per_port_overcurrent_mode;
  logic transaction_busy, suspended_state, global_overcurrent_in, hit;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [2:0] downstream_port_count;
  logic [15:0] per_port_power_mask;
  logic [3:0] attach, slow, port_overcurrent_in;
  wire [31:0] reg_rdata;
  wire [3:0] port_power, connect_in, low_speed_in;
  wire reg_ack, remote_wakeup_enable_flag, resume_request;
  int mismatches, num_checks;
  root_hub_global_status_regs u_root_hub_global_status_regs (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .downstream_port_count(downstream_port_count), .power_switch_mode(power_switch_mode),
    .per_port_overcurrent_mode(per_port_overcurrent_mode), .per_port_power_mask(per_port_power_mask),
    .transaction_busy(transaction_busy), .suspended_state(suspended_state),
    .global_overcurrent_in(global_overcurrent_in), .connect_in(connect_in), .low_speed_in(low_speed_in),
    .port_overcurrent_in(port_overcurrent_in), .port_power(port_power),
    .remote_wakeup_enable_flag(remote_wakeup_enable_flag), .resume_request(resume_request)
  );
  root_hub_port_model u_root_hub_port_model (
    .attach(attach), .slow(slow), .port_power(port_power), .connect_in(connect_in),
    .low_speed_in(low_speed_in)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tick(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    tick(1);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  task automatic watch(input logic exp);
    hit = 1'b0;
    repeat (6)
    begin
      tick(1);
      hit = hit | resume_request;
    end
    chk(hit, exp);
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    #20000;
    mismatches++;
    end_of_test;
  end
  initial
  begin
    {rst_b, reg_wr, reg_rd, power_switch_mode, per_port_overcurrent_mode} = 5'h00;
    {transaction_busy, suspended_state, global_overcurrent_in} = 3'h0;
    {reg_addr, reg_wdata, per_port_power_mask, attach, slow, port_overcurrent_in} = '0;
    downstream_port_count = 3'h4;
    tick(6);
    rst_b = 1'b1;
    rd(8'h50, 32'h0);
    rd(8'h54, 32'h0);
    wr(8'h50, 32'h8000);
    rd(8'h50, 32'h8000);
    wr(8'h50, 32'h0);
    chk(remote_wakeup_enable_flag, 1'b1);
    wr(8'h50, 32'h80008000);
    chk(remote_wakeup_enable_flag, 1'b0);
    attach = 4'h1;
    slow = 4'h1;
    wr(8'h50, 32'h10000);
    rd(8'h50, 32'h0);
    chk(port_power, 4'hF);
    rd(8'h54, 32'h10301);
    rd(8'h5C, 32'h100);
    wr(8'h54, 32'h10002);
    rd(8'h54, 32'h303);
    wr(8'h50, 32'h1);
    rd(8'h50, 32'h0);
    chk(port_power, 4'h0);
    rd(8'h54, 32'h30000);
    wr(8'h54, 32'h30000);
    power_switch_mode = 1'b1;
    per_port_power_mask = 16'h0006;
    wr(8'h50, 32'h10000);
    chk(port_power, 4'hC);
    wr(8'h54, 32'h100);
    wr(8'h50, 32'h1);
    chk(port_power, 4'h1);
    downstream_port_count = 3'h2;
    rd(8'h5C, 32'h0);
    rd(8'h64, 32'h0);
    // power off held back until the bus goes idle
    transaction_busy = 1'b1;
    wr(8'h54, 32'h200);
    tick(3);
    chk(port_power, 4'h1);
    transaction_busy = 1'b0;
    tick(2);
    chk(port_power, 4'h0);
    suspended_state = 1'b1;
    wr(8'h50, 32'h8000);
    wr(8'h54, 32'h100);
    watch(1'b1);
    wr(8'h50, 32'h80000000);
    wr(8'h54, 32'h200);
    watch(1'b0);
    suspended_state = 1'b0;
    global_overcurrent_in = 1'b1;
    tick(3);
    rd(8'h50, 32'h20002);
    wr(8'h50, 32'h20000);
    rd(8'h50, 32'h2);
    global_overcurrent_in = 1'b0;
    tick(3);
    wr(8'h50, 32'h0);
    rd(8'h50, 32'h20000);
    wr(8'h50, 32'h20000);
    // overcurrent rises on the very edge that carries the clear
    tick(1);
    {reg_addr, reg_wdata, reg_wr, global_overcurrent_in} = {8'h50, 32'h20000, 2'b11};
    tick(1);
    reg_wr = 1'b0;
    rd(8'h50, 32'h20002);
    per_port_overcurrent_mode = 1'b1;
    tick(3);
    wr(8'h50, 32'h20000);
    rd(8'h50, 32'h0);
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
